// >>> hw/exec_defines.svh
// constants for the move, return and rotate execution block
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// opcode masks and match values, 14-bit instruction word
`define OPC_COPY_MASK   14'h3F00
`define OPC_COPY_VAL    14'h0800
`define OPC_ROTL_MASK   14'h3F00
`define OPC_ROTL_VAL    14'h0D00
`define OPC_STORE_MASK  14'h3F80
`define OPC_STORE_VAL   14'h0080
`define OPC_LIT_MASK    14'h3C00
`define OPC_LOADK_VAL   14'h3000
`define OPC_RETK_VAL    14'h3400
`define OPC_IRET_MASK   14'h3FFF
`define OPC_IRET_VAL    14'h0009

// instruction fields
`define FLD_FADDR_LSB   0
`define FLD_FADDR_MSB   6
`define FLD_TARGET_BIT  7
`define FLD_IMM_LSB     0
`define FLD_IMM_MSB     7

// register port offsets
`define OFS_ACCUM       8'h00
`define OFS_FLAGS       8'h01
`define OFS_PC_LO       8'h02
`define OFS_PC_HI       8'h03
`define OFS_CTRL        8'h04
`define OFS_STATUS      8'h05
`define OFS_LAST_OP     8'h06
`define OFS_COUNT_LO    8'h07
`define OFS_COUNT_HI    8'h08

// flag and control register bit positions
`define FLAG_ZERO_BIT   0
`define FLAG_CARRY_BIT  1
`define FLAG_IRQ_BIT    2
`define CTRL_HALT_BIT   0

// reset values
`define RST_ACCUM       8'h00
`define RST_PC          13'h0000
`define RST_COUNT       16'h0000

`endif

// >>> hw/exec_pkg.sv
// types shared by the execution block
package exec_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [13:0] instr_t;
  typedef logic [12:0] pc_t;
  typedef logic [15:0] count_t;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_EXEC,
    ST_DISCARD
  } state_e;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_COPY,
    OP_ROTL,
    OP_STORE,
    OP_LOADK,
    OP_RETK,
    OP_IRET,
    OP_NOP
  } opclass_e;
endpackage

// >>> hw/file_reg_mem.sv
// file register memory, registered read data
`timescale 1ns/1ns
module file_reg_mem #(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData
);
  typedef struct packed {
    logic [(1<<ADDR_W)-1:0][DATA_W-1:0] cells;
    logic [DATA_W-1:0]                  rdData;
  } mem_s;

  mem_s mem_r;
  mem_s mem_nxt;

  if (ADDR_W < 1 || ADDR_W > 10 || DATA_W < 1) begin : g_chk
    $error("file_reg_mem: unsupported geometry");
  end

  always_comb begin
    mem_nxt = mem_r;
    // read before write: same-address write shows next cycle
    mem_nxt.rdData = mem_r.cells[rdAddr];
    if (wrEn) begin
      mem_nxt.cells[wrAddr] = wrData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_r <= '0;
    end else begin
      mem_r <= mem_nxt;
    end
  end

  assign rdData = mem_r.rdData;
endmodule

// >>> hw/move_return_rotate_exec.sv
// executes register copy, immediate load, store, nop, returns and rotate left
//
// Function
// RQ1 - copy register to accumulator or back by target bit
// RQ2 - copy sets zero flag from moved value
// RQ3 - immediate load into accumulator, flags untouched
// RQ4 - immediate load ignores its don't-care bits
// RQ5 - interrupt return pops stack, sets irq enable
// RQ6 - store accumulator to register, flags untouched
// RQ7 - value return loads immediate into accumulator
// RQ8 - value return pops stack into counter
// RQ9 - value return takes two cycles, second discarded
// RQ10 - rotate left through carry, carry only flag
// RQ11 - rotate result to accumulator or register
// RQ12 - old carry in bit 0, bit 7 out
// RQ13 - nop only advances counter, one cycle
`timescale 1ns/1ns
`include "exec_defines.svh"
module move_return_rotate_exec #(
  parameter int FADDR_W = 7,
  parameter int DATA_W  = 8
) (
  input  wire logic            core_clk,
  input  wire logic            rst,
  input  wire logic            instrValid,
  input  wire exec_pkg::instr_t instrWord,
  input  wire exec_pkg::pc_t   stackTop,
  input  wire logic [7:0]      busAddr,
  input  wire exec_pkg::byte_t busWrData,
  input  wire logic            busWrEn,
  input  wire logic            busRdEn,
  output exec_pkg::byte_t      busRdData,
  output logic                 instrReady,
  output exec_pkg::pc_t        progCounter,
  output exec_pkg::byte_t      accum,
  output logic                 zeroFlag,
  output logic                 carryFlag,
  output logic                 masterIrqEnable,
  output logic                 stackPop,
  output logic                 fetchDiscard
);
  import exec_pkg::*;

  typedef struct packed {
    state_e             st;
    logic [FADDR_W-1:0] fAddr;
    logic               toReg;
    logic               isRot;
    byte_t              accum;
    logic               zero;
    logic               carry;
    logic               irqEn;
    pc_t                pc;
    logic               ready;
    logic               halt;
    logic               stackPop;
    logic               fetchDiscard;
    byte_t              busRdData;
    opclass_e           lastOp;
    count_t             retired;
  } exec_s;

  exec_s s_r;
  exec_s s_nxt;

  logic               memWe;
  logic [FADDR_W-1:0] memWaddr;
  byte_t              memWdata;
  logic [FADDR_W-1:0] memRaddr;
  byte_t              memRdata;
  byte_t              rotResult;

  localparam exec_s RST_STATE = '{
    st:           ST_RUN,
    fAddr:        '0,
    toReg:        1'b0,
    isRot:        1'b0,
    accum:        `RST_ACCUM,
    zero:         1'b0,
    carry:        1'b0,
    irqEn:        1'b0,
    pc:           `RST_PC,
    ready:        1'b1,
    halt:         1'b0,
    stackPop:     1'b0,
    fetchDiscard: 1'b0,
    busRdData:    8'h00,
    lastOp:       OP_NONE,
    retired:      `RST_COUNT
  };

  if (FADDR_W != 7 || DATA_W != 8) begin : g_chk
    $error("move_return_rotate_exec: only 7-bit addresses and 8-bit data");
  end

  file_reg_mem #(
    .ADDR_W (FADDR_W),
    .DATA_W (DATA_W)
  ) u_file_regs (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (memWe),
    .wrAddr   (memWaddr),
    .wrData   (memWdata),
    .rdAddr   (memRaddr),
    .rdData   (memRdata)
  );

  // old carry enters at the bottom, old bit 7 leaves as carry
  assign rotResult = {memRdata[6:0], s_r.carry}; // see RQ12

  always_comb begin
    s_nxt              = s_r;
    s_nxt.stackPop     = 1'b0;
    s_nxt.fetchDiscard = 1'b0;
    s_nxt.busRdData    = 8'h00;
    memWe              = 1'b0;
    memWaddr           = s_r.fAddr;
    memWdata           = s_r.accum;
    // operand read is launched on the accept edge for every word
    memRaddr           = instrWord[`FLD_FADDR_MSB:`FLD_FADDR_LSB];

    // register port writes first, execution below overrides them
    if (busWrEn) begin
      if (busAddr == `OFS_ACCUM) begin
        s_nxt.accum = busWrData;
      end else if (busAddr == `OFS_FLAGS) begin
        s_nxt.zero  = busWrData[`FLAG_ZERO_BIT];
        s_nxt.carry = busWrData[`FLAG_CARRY_BIT];
        s_nxt.irqEn = busWrData[`FLAG_IRQ_BIT];
      end else if (busAddr == `OFS_PC_LO) begin
        s_nxt.pc[7:0] = busWrData;
      end else if (busAddr == `OFS_PC_HI) begin
        s_nxt.pc[12:8] = busWrData[4:0];
      end else if (busAddr == `OFS_CTRL) begin
        s_nxt.halt = busWrData[`CTRL_HALT_BIT];
      end
    end

    // reads show state before this edge; unmapped reads give zero
    if (busRdEn) begin
      if (busAddr == `OFS_ACCUM) begin
        s_nxt.busRdData = s_r.accum;
      end else if (busAddr == `OFS_FLAGS) begin
        s_nxt.busRdData = {5'h00, s_r.irqEn, s_r.carry, s_r.zero};
      end else if (busAddr == `OFS_PC_LO) begin
        s_nxt.busRdData = s_r.pc[7:0];
      end else if (busAddr == `OFS_PC_HI) begin
        s_nxt.busRdData = {3'h0, s_r.pc[12:8]};
      end else if (busAddr == `OFS_CTRL) begin
        s_nxt.busRdData = {7'h00, s_r.halt};
      end else if (busAddr == `OFS_STATUS) begin
        s_nxt.busRdData = {5'h00, s_r.ready, s_r.st};
      end else if (busAddr == `OFS_LAST_OP) begin
        s_nxt.busRdData = {5'h00, s_r.lastOp};
      end else if (busAddr == `OFS_COUNT_LO) begin
        s_nxt.busRdData = s_r.retired[7:0];
      end else if (busAddr == `OFS_COUNT_HI) begin
        s_nxt.busRdData = s_r.retired[15:8];
      end
    end

    case (s_r.st)
      ST_RUN: begin
        // halt only blocks new words; a word already taken completes
        s_nxt.ready = ~s_nxt.halt;
        if (instrValid && s_r.ready) begin
          s_nxt.pc      = s_r.pc + 13'h0001;
          s_nxt.retired = s_r.retired + 16'h0001;
          s_nxt.fAddr   = instrWord[`FLD_FADDR_MSB:`FLD_FADDR_LSB];
          s_nxt.toReg   = instrWord[`FLD_TARGET_BIT];
          if ((instrWord & `OPC_COPY_MASK) == `OPC_COPY_VAL) begin
            // operand arrives from memory next cycle
            s_nxt.isRot  = 1'b0;
            s_nxt.lastOp = OP_COPY;
            s_nxt.st     = ST_EXEC;
            s_nxt.ready  = 1'b0;
          end else if ((instrWord & `OPC_ROTL_MASK) == `OPC_ROTL_VAL) begin
            s_nxt.isRot  = 1'b1;
            s_nxt.lastOp = OP_ROTL;
            s_nxt.st     = ST_EXEC;
            s_nxt.ready  = 1'b0;
          end else if ((instrWord & `OPC_STORE_MASK) == `OPC_STORE_VAL) begin
            memWe        = 1'b1; // see RQ6
            memWaddr     = instrWord[`FLD_FADDR_MSB:`FLD_FADDR_LSB];
            memWdata     = s_r.accum;
            s_nxt.accum  = s_r.accum;
            s_nxt.lastOp = OP_STORE;
          end else if ((instrWord & `OPC_LIT_MASK) == `OPC_LOADK_VAL) begin
            // bits 9:8 are masked out of the match, see RQ4
            s_nxt.accum  = instrWord[`FLD_IMM_MSB:`FLD_IMM_LSB]; // see RQ3
            s_nxt.zero   = s_r.zero;
            s_nxt.carry  = s_r.carry;
            s_nxt.lastOp = OP_LOADK;
          end else if ((instrWord & `OPC_LIT_MASK) == `OPC_RETK_VAL) begin
            s_nxt.accum        = instrWord[`FLD_IMM_MSB:`FLD_IMM_LSB]; // see RQ7
            s_nxt.pc           = stackTop; // see RQ8
            s_nxt.stackPop     = 1'b1;
            s_nxt.zero         = s_r.zero;
            s_nxt.carry        = s_r.carry;
            s_nxt.fetchDiscard = 1'b1; // see RQ9
            s_nxt.st           = ST_DISCARD;
            s_nxt.ready        = 1'b0;
            s_nxt.lastOp       = OP_RETK;
          end else if ((instrWord & `OPC_IRET_MASK) == `OPC_IRET_VAL) begin
            s_nxt.pc           = stackTop; // see RQ5
            s_nxt.stackPop     = 1'b1;
            s_nxt.irqEn        = 1'b1;
            s_nxt.zero         = s_r.zero;
            s_nxt.carry        = s_r.carry;
            s_nxt.fetchDiscard = 1'b1;
            s_nxt.st           = ST_DISCARD;
            s_nxt.ready        = 1'b0;
            s_nxt.lastOp       = OP_IRET;
          end else begin
            // nop and any word outside this group: counter only
            s_nxt.accum  = s_r.accum; // see RQ13
            s_nxt.zero   = s_r.zero;
            s_nxt.carry  = s_r.carry;
            s_nxt.lastOp = OP_NOP;
          end
        end
      end
      ST_EXEC: begin
        if (s_r.isRot) begin
          s_nxt.carry = memRdata[7]; // see RQ10
          s_nxt.zero  = s_r.zero;
          if (s_r.toReg) begin
            memWe    = 1'b1; // see RQ11
            memWdata = rotResult;
          end else begin
            s_nxt.accum = rotResult;
          end
        end else begin
          s_nxt.zero  = (memRdata == 8'h00); // see RQ2
          s_nxt.carry = s_r.carry;
          if (!s_r.toReg) begin
            s_nxt.accum = memRdata; // see RQ1
          end
          // target bit 1 writes the same value back, so nothing to store
        end
        s_nxt.st    = ST_RUN;
        s_nxt.ready = ~s_nxt.halt;
      end
      ST_DISCARD: begin
        // the word fetched behind a return is dropped here
        s_nxt.st    = ST_RUN;
        s_nxt.ready = ~s_nxt.halt;
      end
      default: begin
        s_nxt.st    = ST_RUN;
        s_nxt.ready = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_r <= RST_STATE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign busRdData       = s_r.busRdData;
  assign instrReady      = s_r.ready;
  assign progCounter     = s_r.pc;
  assign accum           = s_r.accum;
  assign zeroFlag        = s_r.zero;
  assign carryFlag       = s_r.carry;
  assign masterIrqEnable = s_r.irqEn;
  assign stackPop        = s_r.stackPop;
  assign fetchDiscard    = s_r.fetchDiscard;
endmodule

// >>> verif/exec_checker.sv
// assertions on the execution block ports
`timescale 1ns/1ns
module exec_checker (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             instrValid,
  input wire exec_pkg::instr_t instrWord,
  input wire exec_pkg::pc_t    stackTop,
  input wire logic             instrReady,
  input wire exec_pkg::pc_t    progCounter,
  input wire exec_pkg::byte_t  accum,
  input wire logic             zeroFlag,
  input wire logic             carryFlag,
  input wire logic             masterIrqEnable,
  input wire logic             stackPop,
  input wire logic             fetchDiscard
);
  import exec_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic tk;
  assign tk = instrValid && instrReady;
  chk_iret_pops: assert property (tk && instrWord == 14'h0009 |=>
    progCounter == $past(stackTop) && masterIrqEnable && stackPop) else $error("iret");
  chk_retk_value: assert property (tk && (instrWord & 14'h3C00) == 14'h3400 |=>
    accum == $past(instrWord[7:0]) && progCounter == $past(stackTop) && fetchDiscard
    ##1 instrReady && !stackPop) else $error("value return");
  chk_loadk_flags: assert property (tk && (instrWord & 14'h3C00) == 14'h3000 |=>
    accum == $past(instrWord[7:0]) && $stable(zeroFlag) && $stable(carryFlag))
    else $error("load immediate");
  chk_rotl_zero: assert property (tk && (instrWord & 14'h3F00) == 14'h0D00 |=>
    !instrReady && $stable(zeroFlag) ##1 instrReady && $stable(zeroFlag)) else $error("rotate");
  chk_copy_zero: assert property (tk && (instrWord & 14'h3F80) == 14'h0800 |=>
    $stable(carryFlag) ##1 zeroFlag == (accum == 8'h00) && $stable(carryFlag))
    else $error("copy zero");
  chk_store_keep: assert property (tk && (instrWord & 14'h3F80) == 14'h0080 |=>
    $stable(zeroFlag) && $stable(carryFlag) && $stable(accum)
    && progCounter == $past(progCounter) + 13'h1) else $error("store");
  chk_nop_pc: assert property (tk && instrWord == 14'h3FFF |=>
    progCounter == $past(progCounter) + 13'h1 && $stable(accum) && instrReady && !stackPop)
    else $error("nop");
  chk_pop_pulse: assert property (stackPop |-> fetchDiscard && !instrReady
    ##1 !stackPop && !fetchDiscard) else $error("pop pulse");
endmodule

// >>> verif/move_return_rotate_exec_tb.sv
// self-checking bench for the execution block
`timescale 1ns/1ns
module move_return_rotate_exec_tb;
  import exec_pkg::*;
  logic        core_clk, rst, instrValid, busWrEn, busRdEn, instrReady;
  logic        zeroFlag, carryFlag, masterIrqEnable, stackPop, fetchDiscard;
  instr_t      instrWord, w;
  pc_t         stackTop, progCounter, pc;
  logic [7:0]  busAddr;
  byte_t       busWrData, busRdData, accum, acc;
  byte_t       mem [128];
  logic        z, c, irq;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int unsigned seed = 82355;
  int unsigned r;
  int          cl;
  logic [6:0]  a;
  instr_t      base [7] = '{14'h0800, 14'h0D00, 14'h0080, 14'h3000, 14'h3400,
                            14'h0009, 14'h3FFF};
  move_return_rotate_exec dut_u (.core_clk(core_clk), .rst(rst), .instrValid(instrValid),
    .instrWord(instrWord), .stackTop(stackTop), .busAddr(busAddr), .busWrData(busWrData),
    .busWrEn(busWrEn), .busRdEn(busRdEn), .busRdData(busRdData), .instrReady(instrReady),
    .progCounter(progCounter), .accum(accum), .zeroFlag(zeroFlag), .carryFlag(carryFlag),
    .masterIrqEnable(masterIrqEnable), .stackPop(stackPop), .fetchDiscard(fetchDiscard));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic ex(input instr_t wd, input pc_t st);
    byte_t v;
    logic  ret;
    v = mem[wd[6:0]];
    ret = (wd & 14'h3C00) == 14'h3400 || wd == 14'h0009;
    instrValid <= 1'b1;
    instrWord <= wd;
    stackTop <= st;
    @(posedge core_clk);
    instrValid <= 1'b0;
    pc = ret ? st : pc + 13'h1;
    if ((wd & 14'h3F00) == 14'h0800) begin
      z = v == 8'h00;
      if (!wd[7]) acc = v;
    end else if ((wd & 14'h3F00) == 14'h0D00) begin
      v = {v[6:0], c};
      c = mem[wd[6:0]][7];
      if (wd[7]) mem[wd[6:0]] = v;
      else acc = v;
    end else if ((wd & 14'h3F80) == 14'h0080) mem[wd[6:0]] = acc;
    else if (wd[13:11] == 3'b110) acc = wd[7:0];
    else if (wd == 14'h0009) irq = 1'b1;
    #1;
    cmp("stackPop", 13'(ret), 13'(stackPop));
    cmp("fetchDiscard", 13'(ret), 13'(fetchDiscard));
    // copy and rotate land one edge late, so wait two more
    repeat (2) @(posedge core_clk);
    #1;
    cmp("progCounter", pc, progCounter);
    cmp("accum", 13'(acc), 13'(accum));
    cmp("flags", 13'({irq, c, z}), 13'({masterIrqEnable, carryFlag, zeroFlag}));
  endtask
  task automatic bus(input logic wr, input logic [7:0] ad, input byte_t d);
    busWrEn <= wr;
    busRdEn <= !wr;
    busAddr <= ad;
    busWrData <= d;
    @(posedge core_clk);
    busWrEn <= 1'b0;
    busRdEn <= 1'b0;
    #1;
    if (!wr) cmp("busRdData", 13'(d), 13'(busRdData));
    // one idle edge so the next call never re-drives a strobe in this time step
    @(posedge core_clk);
    #1;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #300000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    {rst, instrValid, busWrEn, busRdEn} = 4'b1000;
    {instrWord, stackTop, busAddr, busWrData} = '0;
    {acc, z, c, irq, pc} = '0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    ex(14'h0805, 13'h0000);
    ex(14'h3355, 13'h0000);
    ex(14'h00FF, 13'h0000);
    ex(14'h087F, 13'h0000);
    ex(14'h0DFF, 13'h0000);
    ex(14'h0DFF, 13'h0000);
    ex(14'h0D7F, 13'h0000);
    ex(14'h08FF, 13'h0000);
    ex(14'h37A5, 13'h1FFF);
    ex(14'h0009, 13'h0123);
    ex(14'h3FFF, 13'h0000);
    $display("directed test done");
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      cl = r[31:16] % 7;
      a = r[3] ? 7'h7F : {4'h0, r[2:0]};
      w = base[cl];
      if (cl < 2) w = w | {6'h00, r[4], a};
      else if (cl == 2) w = w | {7'h00, a};
      else if (cl < 5) w = w | {4'h0, r[9:0]};
      ex(w, r[28:16]);
    end
    $display("random test done");
    bus(1'b0, 8'h00, acc);
    bus(1'b0, 8'h01, {5'h00, irq, c, z});
    bus(1'b0, 8'h7F, 8'h00);
    bus(1'b1, 8'h04, 8'h01);
    instrValid <= 1'b1;
    instrWord <= 14'h3FFF;
    repeat (3) @(posedge core_clk);
    instrValid <= 1'b0;
    #1;
    cmp("progCounter", pc, progCounter);
    bus(1'b1, 8'h04, 8'h00);
    ex(14'h3FFF, 13'h0000);
    $display("register port test done");
    stop_test();
  end
endmodule
bind move_return_rotate_exec exec_checker chk_u (.core_clk(core_clk), .rst(rst),
  .instrValid(instrValid), .instrWord(instrWord), .stackTop(stackTop),
  .instrReady(instrReady), .progCounter(progCounter), .accum(accum), .zeroFlag(zeroFlag),
  .carryFlag(carryFlag), .masterIrqEnable(masterIrqEnable), .stackPop(stackPop),
  .fetchDiscard(fetchDiscard));
